// ===== dllc_top.sv
`include "dllc_consts.svh"

module dllc_top
    import dllc_pkg::*;
#(
    parameter int CNT_W = 14,
    parameter int DIV_W = 10
)
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Register write and read port from the serial front end
    input  wire logic        reg_wr_en,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [31:0] reg_wr_data,
    output logic [31:0]      reg_rd_data,
    // Phase detector pins of the cleaner loop
    input  wire logic        cleaner_pd_clk,
    input  wire logic [3:0]  cleaner_window_hit,
    // Phase detector pins of the synthesizer loop
    input  wire logic        synth_pd_clk,
    input  wire logic [3:0]  synth_window_hit,
    // Lock indications
    output logic             cleaner_lock,
    output logic             synth_lock,
    // Holdover DAC update
    output logic             dac_update,
    // Charge pump controls
    output logic             cleaner_pump_drive_en,
    output logic [11:0]      cleaner_pump_current_ua,
    output logic             cleaner_pump_polarity,
    output logic             synth_pump_drive_en,
    output logic [11:0]      synth_pump_current_ua,
    output logic             synth_pump_polarity,
    output logic             reference_doubler_enable,
    // Zero-delay path delays
    output logic [10:0]      feedback_path_delay_ps,
    output logic [10:0]      reference_path_delay_ps,
    // Loop filter selections
    output logic [5:0]       third_pole_capacitor_pf,
    output logic [14:0]      fourth_pole_resistor_ohm,
    output logic [14:0]      third_pole_resistor_ohm
);

    // ----------------------------------------------------------------
    // Lookup functions
    // ----------------------------------------------------------------
    function automatic logic [14:0] resistor_ohm(input logic [2:0] code);
        unique case (code)
            3'h0:    resistor_ohm = 15'd200;
            3'h1:    resistor_ohm = 15'd1000;
            3'h2:    resistor_ohm = 15'd2000;
            3'h3:    resistor_ohm = 15'd4000;
            3'h4:    resistor_ohm = 15'd16000;
            default: resistor_ohm = 15'h0000;
        endcase
    endfunction

    function automatic logic [10:0] path_delay_ps(input logic [2:0] code);
        path_delay_ps = 11'(code * `DLLC_DELAY_STEP_PS);
    endfunction

    function automatic logic [5:0] capacitor_pf(input logic [3:0] code);
        unique case (code)
            4'h0:    capacitor_pf = 6'd10;
            4'h1:    capacitor_pf = 6'd11;
            4'h2:    capacitor_pf = 6'd15;
            4'h3:    capacitor_pf = 6'd16;
            4'h4:    capacitor_pf = 6'd19;
            4'h5:    capacitor_pf = 6'd20;
            4'h6:    capacitor_pf = 6'd24;
            4'h7:    capacitor_pf = 6'd25;
            4'h8:    capacitor_pf = 6'd29;
            4'h9:    capacitor_pf = 6'd30;
            4'hA:    capacitor_pf = 6'd33;
            4'hB:    capacitor_pf = 6'd34;
            4'hC:    capacitor_pf = 6'd38;
            4'hD:    capacitor_pf = 6'd39;
            default: capacitor_pf = 6'h00;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [31:0] loop_filter_delay_window_cfg;
    logic [31:0] dac_clock_and_lock_count_cfg;
    logic [31:0] synth_loop_charge_pump_cfg;
    logic [31:0] cleaner_loop_charge_pump_cfg;
    logic [31:0] next_filter_cfg;
    logic [31:0] next_dac_cfg;
    logic [31:0] next_synth_cfg;
    logic [31:0] next_cleaner_cfg;
    logic [31:0] next_rd_data;

    always_comb
    begin
        next_filter_cfg  = loop_filter_delay_window_cfg;
        next_dac_cfg     = dac_clock_and_lock_count_cfg;
        next_synth_cfg   = synth_loop_charge_pump_cfg;
        next_cleaner_cfg = cleaner_loop_charge_pump_cfg;
        if (reg_wr_en)
        begin
            unique case (reg_addr)
                `DLLC_REG_FILTER_DELAY: next_filter_cfg  = reg_wr_data;
                `DLLC_REG_DAC_LOCK:     next_dac_cfg     = reg_wr_data;
                `DLLC_REG_SYNTH_PUMP:   next_synth_cfg   = reg_wr_data;
                `DLLC_REG_CLEANER_PUMP: next_cleaner_cfg = reg_wr_data;
                default:                next_rd_data     = reg_rd_data;
            endcase
        end
        unique case (reg_addr)
            `DLLC_REG_FILTER_DELAY: next_rd_data = loop_filter_delay_window_cfg;
            `DLLC_REG_DAC_LOCK:     next_rd_data = dac_clock_and_lock_count_cfg;
            `DLLC_REG_SYNTH_PUMP:   next_rd_data = synth_loop_charge_pump_cfg;
            `DLLC_REG_CLEANER_PUMP: next_rd_data = cleaner_loop_charge_pump_cfg;
            default:                next_rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            loop_filter_delay_window_cfg <= `DLLC_RST_FILTER_DELAY;
            dac_clock_and_lock_count_cfg <= `DLLC_RST_DAC_LOCK;
            synth_loop_charge_pump_cfg   <= `DLLC_RST_SYNTH_PUMP;
            cleaner_loop_charge_pump_cfg <= `DLLC_RST_CLEANER_PUMP;
            reg_rd_data                  <= 32'h0000_0000;
        end
        else
        begin
            loop_filter_delay_window_cfg <= next_filter_cfg;
            dac_clock_and_lock_count_cfg <= next_dac_cfg;
            synth_loop_charge_pump_cfg   <= next_synth_cfg;
            cleaner_loop_charge_pump_cfg <= next_cleaner_cfg;
            reg_rd_data                  <= next_rd_data;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and detector clock edges
    // ----------------------------------------------------------------
    logic [9:0] sync_a;
    logic [9:0] sync_b;
    logic [1:0] clk_last;
    logic       cleaner_tick;
    logic       synth_tick;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            sync_a   <= 10'h000;
            sync_b   <= 10'h000;
            clk_last <= 2'h0;
        end
        else
        begin
            sync_a   <= {synth_pd_clk, cleaner_pd_clk,
                         synth_window_hit, cleaner_window_hit};
            sync_b   <= sync_a;
            clk_last <= sync_b[9:8];
        end
    end

    assign cleaner_tick = sync_b[8] & ~clk_last[0];
    assign synth_tick   = sync_b[9] & ~clk_last[1];

    // ----------------------------------------------------------------
    // Lock detectors
    // ----------------------------------------------------------------
    // cleaner window select
    dllc_lock_detect #(.CNT_W(CNT_W)) u_cleaner_detect
    (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .pd_tick    (cleaner_tick),
        .window_hit (sync_b[3:0]),
        .window_sel (loop_filter_delay_window_cfg[`DLLC_WINDOW_MSB:
                                                  `DLLC_WINDOW_LSB]),
        .lock_count (dac_clock_and_lock_count_cfg[`DLLC_COUNT_MSB:
                                                  `DLLC_COUNT_LSB]),
        .locked     (cleaner_lock),
        .count      ()
    );

    dllc_lock_detect #(.CNT_W(CNT_W)) u_synth_detect
    (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .pd_tick    (synth_tick),
        .window_hit (sync_b[7:4]),
        .window_sel (synth_loop_charge_pump_cfg[`DLLC_SYNTH_WINDOW_MSB:
                                                `DLLC_SYNTH_WINDOW_LSB]),
        .lock_count (synth_loop_charge_pump_cfg[`DLLC_COUNT_MSB:
                                                `DLLC_COUNT_LSB]),
        .locked     (synth_lock),
        .count      ()
    );

    // ----------------------------------------------------------------
    // Holdover DAC update divider
    // ----------------------------------------------------------------
    logic [DIV_W-1:0] dac_div_count;
    logic [DIV_W-1:0] next_dac_div_count;
    logic             next_dac_update;
    logic [DIV_W-1:0] dac_divisor;

    assign dac_divisor = dac_clock_and_lock_count_cfg[`DLLC_DAC_DIV_MSB:
                                                      `DLLC_DAC_DIV_LSB];

    always_comb
    begin
        next_dac_div_count = dac_div_count;
        next_dac_update    = 1'b0;
        if (cleaner_tick && dac_divisor != '0)
        begin
            if (dac_div_count + 1'b1 >= dac_divisor)
            begin
                next_dac_div_count = '0;
                next_dac_update    = 1'b1;
            end
            else
            begin
                next_dac_div_count = dac_div_count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            dac_div_count <= '0;
            dac_update    <= 1'b0;
        end
        else
        begin
            dac_div_count <= next_dac_div_count;
            dac_update    <= next_dac_update;
        end
    end

    // ----------------------------------------------------------------
    // Analog controls
    // ----------------------------------------------------------------
    logic        synth_hiz;
    logic        cleaner_hiz;
    logic [1:0]  synth_gain;
    logic [1:0]  cleaner_gain;
    logic [11:0] next_synth_ua;
    logic [11:0] next_cleaner_ua;

    assign synth_hiz    = synth_loop_charge_pump_cfg[`DLLC_HIZ_BIT];
    assign cleaner_hiz  = cleaner_loop_charge_pump_cfg[`DLLC_HIZ_BIT];
    assign synth_gain   = synth_loop_charge_pump_cfg[`DLLC_GAIN_MSB:
                                                     `DLLC_GAIN_LSB];
    assign cleaner_gain = cleaner_loop_charge_pump_cfg[`DLLC_GAIN_MSB:
                                                       `DLLC_GAIN_LSB];

    always_comb
    begin
        unique case (synth_gain)
            2'h0: next_synth_ua = 12'd100;
            2'h1: next_synth_ua = 12'd400;
            2'h2: next_synth_ua = 12'd1600;
            2'h3: next_synth_ua = 12'd3200;
        endcase
        if (synth_hiz)
        begin
            next_synth_ua = 12'h000;
        end
        unique case (cleaner_gain)
            2'h0: next_cleaner_ua = 12'd100;
            2'h1: next_cleaner_ua = 12'd200;
            2'h2: next_cleaner_ua = 12'd400;
            2'h3: next_cleaner_ua = 12'd1600;
        endcase
        if (cleaner_hiz)
        begin
            next_cleaner_ua = 12'h000;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            synth_pump_drive_en      <= 1'b0;
            synth_pump_current_ua    <= 12'h000;
            cleaner_pump_drive_en    <= 1'b0;
            cleaner_pump_current_ua  <= 12'h000;
            synth_pump_polarity      <= 1'b0;
            cleaner_pump_polarity    <= 1'b0;
            reference_doubler_enable <= 1'b0;
            feedback_path_delay_ps   <= 11'h000;
            reference_path_delay_ps  <= 11'h000;
            third_pole_capacitor_pf  <= 6'h00;
            fourth_pole_resistor_ohm <= 15'h0000;
            third_pole_resistor_ohm  <= 15'h0000;
        end
        else
        begin
            synth_pump_drive_en      <= ~synth_hiz;
            synth_pump_current_ua    <= next_synth_ua;
            cleaner_pump_drive_en    <= ~cleaner_hiz;
            cleaner_pump_current_ua  <= next_cleaner_ua;
            synth_pump_polarity      <=
                synth_loop_charge_pump_cfg[`DLLC_POLARITY_BIT];
            cleaner_pump_polarity    <=
                cleaner_loop_charge_pump_cfg[`DLLC_POLARITY_BIT];
            reference_doubler_enable <=
                synth_loop_charge_pump_cfg[`DLLC_DOUBLER_BIT];
            feedback_path_delay_ps   <= path_delay_ps(
                loop_filter_delay_window_cfg[`DLLC_FB_DELAY_MSB:
                                             `DLLC_FB_DELAY_LSB]);
            reference_path_delay_ps  <= path_delay_ps(
                loop_filter_delay_window_cfg[`DLLC_REF_DELAY_MSB:
                                             `DLLC_REF_DELAY_LSB]);
            third_pole_capacitor_pf  <= capacitor_pf(
                loop_filter_delay_window_cfg[`DLLC_THIRD_CAP_MSB:
                                             `DLLC_THIRD_CAP_LSB]);
            fourth_pole_resistor_ohm <= resistor_ohm(
                loop_filter_delay_window_cfg[`DLLC_FOURTH_RES_MSB:
                                             `DLLC_FOURTH_RES_LSB]);
            third_pole_resistor_ohm  <= resistor_ohm(
                loop_filter_delay_window_cfg[`DLLC_THIRD_RES_MSB:
                                             `DLLC_THIRD_RES_LSB]);
        end
    end

endmodule

// ===== dllc_consts.svh
`ifndef DLLC_CONSTS_SVH
`define DLLC_CONSTS_SVH
// Notes on behaviour
// - Cleaner window field picks one of four windows
// - Cleaner phase error inside window increments counter
// - Cleaner lock after 14-bit count; zero reserved
// - Synth phase error inside window increments counter
// - Synth lock after 14-bit count; zero reserved
// - DAC update clock divides cleaner detector clock
// - Synth pump hiz overrides gain; gain selects current
// - Cleaner pump hiz overrides; gain selects current
// - Synth polarity bit; internal oscillator needs negative
// - Cleaner polarity bit selects slope
// - Doubler bit doubles synth phase detector reference
// - Feedback path delay is code times step
// - Reference path delay is code times step
// - Fourth-pole resistor codes 0-4; 5-7 reserved
// - Third-pole resistor codes 0-4; 5-7 reserved

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define DLLC_ADDR_W            5
`define DLLC_REG_FILTER_DELAY  5'h18
`define DLLC_REG_DAC_LOCK      5'h19
`define DLLC_REG_SYNTH_PUMP    5'h1A
`define DLLC_REG_CLEANER_PUMP  5'h1B

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DLLC_RST_FILTER_DELAY  32'h0000_0000
`define DLLC_RST_DAC_LOCK      32'h0040_0040
`define DLLC_RST_SYNTH_PUMP    32'h8000_0040
`define DLLC_RST_CLEANER_PUMP  32'h0000_0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DLLC_THIRD_CAP_MSB     27
`define DLLC_THIRD_CAP_LSB     24
`define DLLC_FOURTH_RES_MSB    22
`define DLLC_FOURTH_RES_LSB    20
`define DLLC_THIRD_RES_MSB     18
`define DLLC_THIRD_RES_LSB     16
`define DLLC_FB_DELAY_MSB      14
`define DLLC_FB_DELAY_LSB      12
`define DLLC_REF_DELAY_MSB     10
`define DLLC_REF_DELAY_LSB     8
`define DLLC_WINDOW_MSB        7
`define DLLC_WINDOW_LSB        6
`define DLLC_DAC_DIV_MSB       31
`define DLLC_DAC_DIV_LSB       22
`define DLLC_COUNT_MSB         19
`define DLLC_COUNT_LSB         6
`define DLLC_SYNTH_WINDOW_MSB  31
`define DLLC_SYNTH_WINDOW_LSB  30
`define DLLC_DOUBLER_BIT       29
`define DLLC_POLARITY_BIT      28
`define DLLC_GAIN_MSB          27
`define DLLC_GAIN_LSB          26
`define DLLC_HIZ_BIT           5

// ----------------------------------------------------------------
// Analog settings
// ----------------------------------------------------------------
`define DLLC_DELAY_STEP_PS     11'd205
`define DLLC_SYNTH_WINDOW_CODE 2'h2
`endif

// ===== dllc_pkg.sv
package dllc_pkg;
    typedef enum logic [1:0]
    {
        LD_IDLE  = 2'b00,
        LD_COUNT = 2'b01,
        LD_LOCK  = 2'b11
    } dllc_lock_state_t;
endpackage

// ===== dllc_lock_detect.sv
`include "dllc_consts.svh"

module dllc_lock_detect
    import dllc_pkg::*;
#(
    parameter int CNT_W = 14
)
(
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // Phase detector events, already synchronised
    input  wire logic             pd_tick,
    input  wire logic [3:0]       window_hit,
    // Configuration
    input  wire logic [1:0]       window_sel,
    input  wire logic [CNT_W-1:0] lock_count,
    // Status
    output logic                  locked,
    output logic [CNT_W-1:0]      count
);

    dllc_lock_state_t state;
    dllc_lock_state_t next_state;
    logic [CNT_W-1:0] next_count;
    logic             next_locked;
    logic [CNT_W:0]   count_inc;

    // ----------------------------------------------------------------
    // Qualification counter
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state  = state;
        next_count  = count;
        count_inc   = {1'b0, count} + {{CNT_W{1'b0}}, 1'b1};
        if (pd_tick)
        begin
            if (window_hit[window_sel] && lock_count != '0)
            begin
                if (count_inc >= {1'b0, lock_count})
                begin
                    next_state = LD_LOCK;
                    next_count = lock_count;
                end
                else
                begin
                    next_state = LD_COUNT;
                    next_count = count_inc[CNT_W-1:0];
                end
            end
            else
            begin
                next_state = LD_IDLE;
                next_count = '0;
            end
        end
        next_locked = (next_state == LD_LOCK);
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state  <= LD_IDLE;
            count  <= '0;
            locked <= 1'b0;
        end
        else
        begin
            state  <= next_state;
            count  <= next_count;
            locked <= next_locked;
        end
    end

endmodule

// ===== dllc_top_chk.sv
module dllc_top_chk
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        reset,
    // Lock detect and DAC update pins
    input wire logic [3:0]  cleaner_window_hit,
    input wire logic [3:0]  synth_window_hit,
    input wire logic        cleaner_lock,
    input wire logic        synth_lock,
    input wire logic        dac_update,
    // Analog selections
    input wire logic        cleaner_pump_drive_en,
    input wire logic [11:0] cleaner_pump_current_ua,
    input wire logic        synth_pump_drive_en,
    input wire logic [11:0] synth_pump_current_ua,
    input wire logic [10:0] feedback_path_delay_ps,
    input wire logic [10:0] reference_path_delay_ps,
    input wire logic [5:0]  third_pole_capacitor_pf,
    input wire logic [14:0] fourth_pole_resistor_ohm,
    input wire logic [14:0] third_pole_resistor_ohm
);
    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    AST_SYNTH_PUMP: assert property (
        synth_pump_drive_en ? synth_pump_current_ua inside
        {12'h064, 12'h190, 12'h640, 12'hC80} : synth_pump_current_ua == 12'h000)
        else $error("synth pump current not in table");
    AST_CLEANER_PUMP: assert property (
        cleaner_pump_drive_en ? cleaner_pump_current_ua inside
        {12'h064, 12'h0C8, 12'h190, 12'h640} : cleaner_pump_current_ua == 12'h0)
        else $error("cleaner pump current not in table");
    AST_FB_DELAY: assert property (
        feedback_path_delay_ps % 11'h0CD == 11'h000
        && feedback_path_delay_ps <= 11'h59B) else $error("feedback delay off step");
    AST_REF_DELAY: assert property (
        reference_path_delay_ps % 11'h0CD == 11'h000
        && reference_path_delay_ps <= 11'h59B) else $error("reference delay off step");
    AST_CAP_TABLE: assert property (
        third_pole_capacitor_pf inside {6'h00, 6'h0A, 6'h0B, 6'h0F, 6'h10, 6'h13,
        6'h14, 6'h18, 6'h19, 6'h1D, 6'h1E, 6'h21, 6'h22, 6'h26, 6'h27})
        else $error("capacitor not in table");
    AST_FOURTH_RES: assert property (
        fourth_pole_resistor_ohm inside {15'h0000, 15'h00C8, 15'h03E8, 15'h07D0,
        15'h0FA0, 15'h3E80}) else $error("fourth pole resistor not in table");
    AST_THIRD_RES: assert property (
        third_pole_resistor_ohm inside {15'h0000, 15'h00C8, 15'h03E8, 15'h07D0,
        15'h0FA0, 15'h3E80}) else $error("third pole resistor not in table");
    AST_DAC_PULSE: assert property (
        dac_update |=> !dac_update) else $error("dac update longer than a cycle");
    AST_CLEANER_LOCK: assert property (
        $rose(cleaner_lock) |-> |$past(cleaner_window_hit, 3))
        else $error("cleaner lock without window hit");
    AST_SYNTH_LOCK: assert property (
        $rose(synth_lock) |-> |$past(synth_window_hit, 3))
        else $error("synth lock without window hit");

    cover property ($rose(cleaner_lock));
    cover property ($rose(synth_lock));
    cover property (dac_update);
    cover property (!synth_pump_drive_en);
endmodule

bind dllc_top dllc_top_chk chk_i
(
    .clk_sys, .reset, .cleaner_window_hit, .synth_window_hit, .cleaner_lock,
    .synth_lock, .dac_update, .cleaner_pump_drive_en, .cleaner_pump_current_ua,
    .synth_pump_drive_en, .synth_pump_current_ua, .feedback_path_delay_ps,
    .reference_path_delay_ps, .third_pole_capacitor_pf,
    .fourth_pole_resistor_ohm, .third_pole_resistor_ohm
);

// ===== dllc_host_model.sv
module dllc_host_model
(
    // Clock
    input  wire logic        clk_sys,
    // Register port
    output logic             reg_wr_en,
    output logic [4:0]       reg_addr,
    output logic [31:0]      reg_wr_data,
    input  wire logic [31:0] reg_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        reg_wr_en = 1'b0;
        reg_addr = 5'h00;
        reg_wr_data = 32'h0000_0000;
    end

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        reg_wr_data <= ~d;
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        repeat (2) @(posedge clk_sys);
        #1;
        d = reg_rd_data;
    endtask
endmodule

// ===== testbench.sv
`include "dllc_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys, reset, reg_wr_en, cleaner_pd_clk, synth_pd_clk;
    logic        cleaner_lock, synth_lock, dac_update, reference_doubler_enable;
    logic        cleaner_pump_drive_en, cleaner_pump_polarity;
    logic        synth_pump_drive_en, synth_pump_polarity;
    logic [4:0]  reg_addr;
    logic [31:0] reg_wr_data, reg_rd_data, d, q;
    logic [3:0]  cleaner_window_hit, synth_window_hit;
    logic [11:0] cleaner_pump_current_ua, synth_pump_current_ua;
    logic [10:0] feedback_path_delay_ps, reference_path_delay_ps;
    logic [5:0]  third_pole_capacitor_pf;
    logic [14:0] fourth_pole_resistor_ohm, third_pole_resistor_ohm;
    int          err_count = 0;
    int          check_count = 0;
    int          dac_n = 0;
    int          i;
    logic [31:0] rst_v [4] = '{`DLLC_RST_FILTER_DELAY, `DLLC_RST_DAC_LOCK,
                               `DLLC_RST_SYNTH_PUMP, `DLLC_RST_CLEANER_PUMP};
    logic [14:0] res_v [5] = '{15'h00C8, 15'h03E8, 15'h07D0, 15'h0FA0, 15'h3E80};
    logic [5:0]  cap_v [5] = '{6'h1E, 6'h21, 6'h22, 6'h26, 6'h27};
    logic [11:0] sg_v [4] = '{12'h064, 12'h190, 12'h640, 12'hC80};
    logic [11:0] cg_v [4] = '{12'h064, 12'h0C8, 12'h190, 12'h640};

    dllc_top dut
    (
        .clk_sys, .reset, .reg_wr_en, .reg_addr, .reg_wr_data, .reg_rd_data,
        .cleaner_pd_clk, .cleaner_window_hit, .synth_pd_clk, .synth_window_hit,
        .cleaner_lock, .synth_lock, .dac_update, .cleaner_pump_drive_en,
        .cleaner_pump_current_ua, .cleaner_pump_polarity, .synth_pump_drive_en,
        .synth_pump_current_ua, .synth_pump_polarity, .reference_doubler_enable,
        .feedback_path_delay_ps, .reference_path_delay_ps,
        .third_pole_capacitor_pf, .fourth_pole_resistor_ohm,
        .third_pole_resistor_ohm
    );

    dllc_host_model host
    (
        .clk_sys, .reg_wr_en, .reg_addr, .reg_wr_data, .reg_rd_data
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
        if (dac_update === 1'b1)
            dac_n <= dac_n + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One phase detector cycle with the given window flags
    task automatic tick(input logic s, input logic [3:0] h);
        @(posedge clk_sys);
        if (s)
            synth_window_hit <= h;
        else
            cleaner_window_hit <= h;
        repeat (3) @(posedge clk_sys);
        if (s)
            synth_pd_clk <= 1'b1;
        else
            cleaner_pd_clk <= 1'b1;
        repeat (4) @(posedge clk_sys);
        synth_pd_clk <= 1'b0;
        cleaner_pd_clk <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        reset = 1'b1;
        cleaner_pd_clk = 1'b0;
        synth_pd_clk = 1'b0;
        cleaner_window_hit = 4'h0;
        synth_window_hit = 4'h0;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        for (i = 0; i < 4; i++)
        begin
            host.rd(5'(`DLLC_REG_FILTER_DELAY + i), q);
            chk(q, rst_v[i]);
        end
        host.rd(5'h05, q);
        chk(q, 32'h0000_0000);
        for (i = 0; i < 5; i++)
        begin
            d = {4'h0, 4'(i + 9), 1'b0, 3'(i), 1'b0, 3'(i), 1'b0, 3'(i + 3),
                 1'b0, 3'(4 - i), 2'h1, 6'h00};
            host.wr(`DLLC_REG_FILTER_DELAY, d);
            host.rd(`DLLC_REG_FILTER_DELAY, q);
            chk(q, d);
            chk(third_pole_capacitor_pf, cap_v[i]);
            chk(fourth_pole_resistor_ohm, res_v[i]);
            chk(third_pole_resistor_ohm, res_v[i]);
            chk(feedback_path_delay_ps, 11'((i + 3) * 11'h0CD));
            chk(reference_path_delay_ps, 11'((4 - i) * 11'h0CD));
        end
        for (i = 0; i < 8; i++)
        begin
            d = {2'h2, i[0], i[1], i[1:0], 6'h00, 14'h0002, i[2], 5'h00};
            host.wr(`DLLC_REG_SYNTH_PUMP, d);
            q = {3'h0, i[1], i[1:0], 20'h00000, i[2], 5'h00};
            host.wr(`DLLC_REG_CLEANER_PUMP, q);
            host.rd(`DLLC_REG_SYNTH_PUMP, q);
            chk(q, d);
            chk(synth_pump_drive_en, !i[2]);
            chk(synth_pump_current_ua, i[2] ? 12'h000 : sg_v[i[1:0]]);
            chk(synth_pump_polarity, i[1]);
            chk(reference_doubler_enable, i[0]);
            chk(cleaner_pump_drive_en, !i[2]);
            chk(cleaner_pump_current_ua, i[2] ? 12'h000 : cg_v[i[1:0]]);
            chk(cleaner_pump_polarity, i[1]);
        end
        host.wr(`DLLC_REG_DAC_LOCK, {10'h003, 2'h0, 14'h0003, 6'h00});
        for (i = 0; i < 4; i++)
        begin
            tick(1'b0, 4'h2);
            chk(cleaner_lock, i >= 2);
        end
        tick(1'b0, 4'hD);
        chk(cleaner_lock, 1'b0);
        host.wr(`DLLC_REG_DAC_LOCK, {10'h003, 2'h0, 14'h0001, 6'h00});
        for (i = 0; i < 4; i++)
        begin
            host.wr(`DLLC_REG_FILTER_DELAY, {24'h000000, 2'(i), 6'h00});
            tick(1'b0, 4'(1 << i));
            chk(cleaner_lock, 1'b1);
            tick(1'b0, ~4'(1 << i));
            chk(cleaner_lock, 1'b0);
        end
        i = dac_n;
        repeat (9) tick(1'b0, 4'h8);
        chk(dac_n - i, 3);
        for (i = 0; i < 3; i++)
        begin
            tick(1'b1, i == 2 ? 4'hB : 4'h4);
            chk(synth_lock, i == 1);
        end
        host.wr(`DLLC_REG_SYNTH_PUMP, 32'h8000_0000);
        repeat (3) tick(1'b1, 4'h4);
        chk(synth_lock, 1'b0);
        stop_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        stop_test();
    end
endmodule
